// file: bench/digital_input_timing_engine_test.sv
`timescale 1ns/1ps
module digital_input_timing_engine_test
   import dte_pkg::*;
;
   logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wr_r, bv, arr, rv, cnt;
   logic [8:0] awa = 9'h0, ara = 9'h0;
   logic [31:0] wd = 32'h0, pat = 32'h0, tm = 32'h0, seed = 32'hD1339860, rd, lines;
   logic [1:0] br, rr;
   logic [2:0] pin, ptp, poe;
   logic [31:0] ctl[4] = '{32'h41, 32'h41, 32'h4D, 32'h6D}, cnts[4] = '{32'h3, 32'h6, 32'h10, 32'h10};
   logic [31:0] exs[4] = '{32'h04, 32'h0C, 32'h13, 32'h20};
   int mismatches = 0, checked = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) tm <= tm + 32'h1;
   dte_io_model u_io (.clk_i(clk), .pattern_i(pat), .lines_o(lines), .pins_o(pin), .cnt_o(cnt));
   dte_engine dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .DI_LINES_I(lines), .PTP_I(pin), .ANALOG_CMP_I(1'b0),
      .OUTPUT_ENGINE_STROBE_I(1'b0), .COUNTER_OUT_I(cnt), .FREQ_OUT_I(tm[2]), .EDGE_CHANGE_EVENT_OUT_I(1'b0),
      .TIME_I(tm), .PTP_O(ptp), .PTP_OE_O(poe), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(br),
      .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [8:0] adr(int e, logic [4:0] o);
      return 9'(e * 32) + {4'h0, o};
   endfunction
   function automatic logic [1:0] resp(logic [8:0] a);
      return (a[8:2] > 7'h40) ? RESP_SLVERR : RESP_OKAY;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] ex);
      checked++;
      if (got !== ex) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk) {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end while (!bv);
      chk({30'h0, br}, {30'h0, resp(a)});
      bre <= 1'b0;
   endtask
   // Read, mask and compare; the response code is checked on every access
   task rdc(input logic [8:0] a, input logic [31:0] ex, input logic [31:0] m);
      @(posedge clk) {ara, arv, rre} <= {a, 2'b11};
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      chk(rd & m, ex);
      chk({30'h0, rr}, {30'h0, resp(a)});
      rre <= 1'b0;
   endtask
   task finish_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      finish_test;
   end
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      for (int e = 0; e < 8; e += 7) begin
         rdc(adr(e, OFF_CTRL), RST_CTRL, 32'hFFFFFFFF);
         rdc(adr(e, OFF_DIV), RST_DIV, 32'hFFFFFFFF);
         rdc(adr(e, OFF_COUNT), RST_COUNT, 32'hFFFFFFFF);
      end
      seed = xs(seed);
      pat <= seed;
      // Finite, finite past FIFO depth, unbuffered left unread, unbuffered with illegal timing
      for (int k = 0; k < 4; k++) begin
         wr(adr(k + 1, OFF_COUNT), cnts[k]);
         wr(adr(k + 1, OFF_CTRL), ctl[k]);
      end
      repeat (60) @(posedge clk);
      for (int k = 0; k < 4; k++) rdc(adr(k + 1, OFF_STAT), exs[k], 32'h3F);
      for (int k = 0; k < 3; k++) rdc(adr(1, OFF_DATA), pat, 32'hFFFFFFFF);
      rdc(adr(1, OFF_DATA), 32'h0, 32'hFFFFFFFF);
      wr(adr(2, OFF_STAT), 32'h08);
      rdc(adr(2, OFF_STAT), 32'h04, 32'h3F);
      rdc(9'h104, 32'h0, 32'hFFFFFFFF);
      wr(9'h180, 32'h0);
      // Pin 0 driven with idle engine 4 strobe, inverted; pins 1 and 2 released
      wr(OFF_ROUTE, 32'h000000C0);
      repeat (2) @(posedge clk);
      chk({26'h0, poe, ptp}, 32'h0000000F);
      finish_test;
   end
endmodule

// file: bench/dte_engine_assertions.sv
`timescale 1ns/1ps
module dte_engine_assertions
   import dte_pkg::*;
(
   input wire logic        CORE_CLK_I,
   input wire logic        RSTN_I,
   input wire logic        S_AXI_AWVALID_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic        S_AXI_WVALID_I,
   input wire logic        S_AXI_WREADY_O,
   input wire logic        S_AXI_BVALID_O,
   input wire logic        S_AXI_BREADY_I,
   input wire logic [1:0]  S_AXI_BRESP_O,
   input wire logic [8:0]  S_AXI_ARADDR_I,
   input wire logic        S_AXI_ARVALID_I,
   input wire logic        S_AXI_ARREADY_O,
   input wire logic        S_AXI_RVALID_O,
   input wire logic        S_AXI_RREADY_I,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0]  S_AXI_RRESP_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);
   sequence ar_take; S_AXI_ARVALID_I && S_AXI_ARREADY_O; endsequence
   sequence wr_take; S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O; endsequence
   chk_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped early");
   chk_rvalid_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read data dropped early");
   chk_read_busy: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O) else $error("read address taken while busy");
   chk_write_busy: assert property (wr_take |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("write taken early");
   chk_read_latency: assert property (ar_take |=> S_AXI_RVALID_O) else $error("read answer late");
   chk_write_latency: assert property (wr_take |-> ##[1:3] S_AXI_BVALID_O) else $error("write answer late");
   chk_unmapped_read: assert property (ar_take ##0 (S_AXI_ARADDR_I[8:2] > 7'h40) |=>
      S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0) else $error("unmapped read not refused");
   chk_mapped_read: assert property (ar_take ##0 (S_AXI_ARADDR_I < 9'h100) |=> S_AXI_RRESP_O == RESP_OKAY)
      else $error("mapped read refused");
endmodule
bind dte_engine dte_engine_assertions u_chk (.*);

// file: bench/dte_io_model.sv
`timescale 1ns/1ps
// Line modules and trigger pins; pins and counter wander freely so unused pin and counter sources are never quiet
module dte_io_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] pattern_i,
   output logic      [31:0] lines_o = 32'h0,
   output logic      [2:0]  pins_o,
   output logic             cnt_o
);
   logic [7:0] tick_reg = 8'h0;
   always @(posedge clk_i) begin
      lines_o  <= pattern_i;
      tick_reg <= tick_reg + 8'h1;
   end
   assign pins_o = tick_reg[7:5];
   assign cnt_o  = tick_reg[3];
endmodule

// file: verilog/dte_engine.sv
`timescale 1ns/1ps
// Contract
// - Capture all lines on selected clock edge
// - Eight independent timing engines
// - Unbuffered mode accepts only valid timing types
// - Late read in unbuffered mode flags warning
// - Sample into full FIFO raises overflow
// - One reading of every channel per sample
// - Divided timebase clock, timebase never output
// - Internal clock sources with selectable polarity
// - Trigger pins or analog compare clock sampling
// - Sample clock inverted on output pin
// - Start on trigger or software command
// - Stop by count, reference, or software
// - Programmable delay before first internal sample
// - Start trigger at absolute time
// - Digital start trigger with edge select
// - Start trigger output is active-high pulse
// - Posttrigger count is size minus pretrigger
// - Reference ignored until pretrigger samples taken
// - Full buffer drops oldest before reference
// - Collect posttrigger samples then complete
// - Reference trigger source, edge, output polarity
// - Pause level holds off sample clock
module dte_engine
   import dte_pkg::*;
#(
   parameter int NUM_LINES  = 32,
   parameter int FIFO_DEPTH = 4
)(
   input  wire logic                 CORE_CLK_I,
   input  wire logic                 RSTN_I,
   input  wire logic [NUM_LINES-1:0] DI_LINES_I,
   input  wire logic [NUM_PINS-1:0]  PTP_I,
   input  wire logic                 ANALOG_CMP_I,
   input  wire logic                 OUTPUT_ENGINE_STROBE_I,
   input  wire logic                 COUNTER_OUT_I,
   input  wire logic                 FREQ_OUT_I,
   input  wire logic                 EDGE_CHANGE_EVENT_OUT_I,
   input  wire logic [31:0]          TIME_I,
   output logic      [NUM_PINS-1:0]  PTP_O,
   output logic      [NUM_PINS-1:0]  PTP_OE_O,
   input  wire logic [8:0]           S_AXI_AWADDR_I,
   input  wire logic                 S_AXI_AWVALID_I,
   output logic                      S_AXI_AWREADY_O,
   input  wire logic [31:0]          S_AXI_WDATA_I,
   input  wire logic [3:0]           S_AXI_WSTRB_I,
   input  wire logic                 S_AXI_WVALID_I,
   output logic                      S_AXI_WREADY_O,
   output logic      [1:0]           S_AXI_BRESP_O,
   output logic                      S_AXI_BVALID_O,
   input  wire logic                 S_AXI_BREADY_I,
   input  wire logic [8:0]           S_AXI_ARADDR_I,
   input  wire logic                 S_AXI_ARVALID_I,
   output logic                      S_AXI_ARREADY_O,
   output logic      [31:0]          S_AXI_RDATA_O,
   output logic      [1:0]           S_AXI_RRESP_O,
   output logic                      S_AXI_RVALID_O,
   input  wire logic                 S_AXI_RREADY_I
);

   localparam int PW = $clog2(FIFO_DEPTH);

   if (NUM_LINES < 1 || NUM_LINES > 32 || FIFO_DEPTH < 2 ||
       (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
      $error("dte_engine: NUM_LINES 1..32, FIFO_DEPTH power of two >= 2");
   end

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [31:0] msk);
      return (old & ~msk) | (dat & msk);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic             rst_meta_reg;
   logic             rst_n_reg;
   logic [7:0]       ext_meta_reg;
   logic [7:0]       ext_sync_reg;
   logic [SRC_W-1:0] src_now;
   logic [SRC_W-1:0] src_prev_reg;
   logic [SRC_W-1:0] rise;
   logic [SRC_W-1:0] fall;
   logic [NUM_ENG-1:0] str_w;
   logic [NUM_ENG-1:0] stp_w;
   logic [NUM_ENG-1:0] refp_w;
   logic [31:0]      rview [NUM_ENG][8];

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // Trigger and clock pins are asynchronous to the core clock
   always_ff @(posedge CORE_CLK_I) begin
      if (!rst_n_reg) begin
         ext_meta_reg <= 8'h00;
         ext_sync_reg <= 8'h00;
         src_prev_reg <= 16'h0000;
      end else begin
         ext_meta_reg <= {EDGE_CHANGE_EVENT_OUT_I, FREQ_OUT_I, COUNTER_OUT_I,
                          OUTPUT_ENGINE_STROBE_I, ANALOG_CMP_I, PTP_I};
         ext_sync_reg <= ext_meta_reg;
         src_prev_reg <= src_now;
      end
   end

   assign src_now = {str_w, ext_sync_reg};
   assign rise    = src_now & ~src_prev_reg;
   assign fall    = ~src_now & src_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   logic        aw_full_reg;
   logic        w_full_reg;
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic [8:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic [31:0] wmask;
   logic        take_aw;
   logic        take_w;
   logic        do_wr;
   logic        aw_full_next;
   logic        w_full_next;
   logic        wr_map;

   assign take_aw      = S_AXI_AWVALID_I & awready_reg;
   assign take_w       = S_AXI_WVALID_I & wready_reg;
   assign do_wr        = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign aw_full_next = take_aw | (aw_full_reg & ~do_wr);
   assign w_full_next  = take_w | (w_full_reg & ~do_wr);
   assign wr_map       = ~aw_addr_reg[8] | (aw_addr_reg[8:2] == OFF_ROUTE[8:2]);

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[8*b +: 8] = {8{w_strb_reg[b]}};
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!rst_n_reg) begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         aw_addr_reg <= 9'h000;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg  <= w_full_next;
         awready_reg <= ~aw_full_next;
         wready_reg  <= ~w_full_next;
         if (take_aw) begin
            aw_addr_reg <= S_AXI_AWADDR_I;
         end
         if (take_w) begin
            w_data_reg <= S_AXI_WDATA_I;
            w_strb_reg <= S_AXI_WSTRB_I;
         end
         if (do_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   logic        arready_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        take_ar;
   logic [31:0] rd_mux;
   logic        rd_map;
   logic [31:0] route_reg;

   assign take_ar = S_AXI_ARVALID_I & arready_reg;
   assign rd_map  = ~S_AXI_ARADDR_I[8] | (S_AXI_ARADDR_I[8:2] == OFF_ROUTE[8:2]);

   always_comb begin
      rd_mux = 32'h00000000;
      if (!S_AXI_ARADDR_I[8]) begin
         rd_mux = rview[S_AXI_ARADDR_I[7:5]][S_AXI_ARADDR_I[4:2]];
      end else if (rd_map) begin
         rd_mux = route_reg;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!rst_n_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= RESP_OKAY;
      end else if (take_ar) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_mux;
         rresp_reg   <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && S_AXI_RREADY_I) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end else if (!rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   assign S_AXI_AWREADY_O = awready_reg;
   assign S_AXI_WREADY_O  = wready_reg;
   assign S_AXI_BVALID_O  = bvalid_reg;
   assign S_AXI_BRESP_O   = bresp_reg;
   assign S_AXI_ARREADY_O = arready_reg;
   assign S_AXI_RVALID_O  = rvalid_reg;
   assign S_AXI_RDATA_O   = rdata_reg;
   assign S_AXI_RRESP_O   = rresp_reg;

   ////////////////////////////////////////////////////////////////////////
   // One independent engine per index, shared by every input task type
   for (genvar e = 0; e < NUM_ENG; e++) begin : g_eng
      logic [31:0]          ctrl_reg, div_reg, cnt_reg, pre_reg, dly_reg, tim_reg;
      logic [15:0]          div_cnt_reg;
      logic [31:0]          dly_cnt_reg, smp_cnt_reg, post_cnt_reg;
      logic                 ovf_reg, late_reg, err_reg, ref_seen_reg;
      logic                 str_reg, stp_reg, refp_reg;
      logic [PW-1:0]        rd_ptr_reg;
      logic [PW:0]          fcnt_reg;
      logic [NUM_LINES-1:0] mem [FIFO_DEPTH];
      dte_state_e           st_reg;
      dte_ctrl_s            cfg, cfg_wr;
      dte_stat_s            stat;
      logic                 hit, start_cmd, stop_cmd, bad_cfg;
      logic [31:0]          clr;
      logic [15:0]          div_last;
      logic                 tb_tick, div_hit, clk_edge, paused, smp;
      logic                 start_hit, ref_hit, ref_take, full, empty;
      logic                 ovr, push, popr, pop_any;
      logic [31:0]          post_tgt;
      logic [PW-1:0]        wp;

      assign cfg       = dte_ctrl_s'(ctrl_reg);
      // A start sent with its own setup word is judged against that word
      assign cfg_wr    = (hit && aw_addr_reg[4:0] == OFF_CTRL) ?
                         dte_ctrl_s'(merge(ctrl_reg, w_data_reg, wmask)) : cfg;
      assign hit       = do_wr & ~aw_addr_reg[8] & (aw_addr_reg[7:5] == 3'(e));
      assign start_cmd = hit & (aw_addr_reg[4:0] == OFF_CTRL) & wmask[0] & w_data_reg[0];
      assign stop_cmd  = hit & (aw_addr_reg[4:0] == OFF_CTRL) & wmask[1] & w_data_reg[1];
      assign clr       = (hit && aw_addr_reg[4:0] == OFF_STAT) ? (w_data_reg & wmask) : 32'h0;

      always_ff @(posedge CORE_CLK_I) begin
         if (!rst_n_reg) begin
            ctrl_reg <= RST_CTRL;
            div_reg  <= RST_DIV;
            cnt_reg  <= RST_COUNT;
            pre_reg  <= RST_ZERO;
            dly_reg  <= RST_ZERO;
            tim_reg  <= RST_ZERO;
         end else if (hit) begin
            case (aw_addr_reg[4:0])
               OFF_CTRL:  ctrl_reg <= merge(ctrl_reg, w_data_reg, wmask) & 32'hFFFFFFFC;
               OFF_DIV:   div_reg  <= merge(div_reg, w_data_reg, wmask);
               OFF_COUNT: cnt_reg  <= merge(cnt_reg, w_data_reg, wmask);
               OFF_PRE:   pre_reg  <= merge(pre_reg, w_data_reg, wmask);
               OFF_DELAY: dly_reg  <= merge(dly_reg, w_data_reg, wmask);
               OFF_TIME:  tim_reg  <= merge(tim_reg, w_data_reg, wmask);
               default:   ;
            endcase
         end
      end

      // Sample clock path
      assign div_last = (div_reg[15:0] <= 16'h0001) ? 16'h0000 : div_reg[15:0] - 16'h0001;
      assign tb_tick  = (cfg.tb_src == SRC_TB_CORE) | rise[cfg.tb_src];
      assign div_hit  = tb_tick & (div_cnt_reg >= div_last);
      assign paused   = cfg.pause_en & (src_now[div_reg[19:16]] == cfg.pause_lvl);

      always_comb begin
         if (cfg.timing == TT_CHG) begin
            clk_edge = rise[SRC_CHG];
         end else if (cfg.int_clk) begin
            clk_edge = div_hit;
         end else begin
            clk_edge = cfg.clk_fall ? fall[cfg.clk_src] : rise[cfg.clk_src];
         end
      end

      // Every strobe not lost to overflow writes one word holding all lines at once
      assign smp = (st_reg == S_RUN) & ~paused & clk_edge;

      always_comb begin
         case (cfg.start_type)
            ST_SW:   start_hit = 1'b1;
            ST_DIG:  start_hit = cfg.start_fall ? fall[cfg.start_src]
                                                : rise[cfg.start_src];
            ST_TIME: start_hit = (TIME_I >= tim_reg);
            default: start_hit = 1'b0;
         endcase
      end

      assign ref_hit  = cfg.ref_fall ? fall[cfg.ref_src] : rise[cfg.ref_src];
      assign ref_take = (st_reg == S_RUN) & (cfg.mode == MD_REF) & ~ref_seen_reg &
                        ref_hit & (smp_cnt_reg >= pre_reg);
      assign post_tgt = cnt_reg - pre_reg;
      assign bad_cfg  = (cfg_wr.timing != TT_SCLK && cfg_wr.timing != TT_CHG) ||
                        (cfg_wr.mode == MD_REF && pre_reg > cnt_reg);

      always_ff @(posedge CORE_CLK_I) begin
         if (!rst_n_reg) begin
            st_reg       <= S_IDLE;
            dly_cnt_reg  <= 32'h0;
            smp_cnt_reg  <= 32'h0;
            post_cnt_reg <= 32'h0;
            ref_seen_reg <= 1'b0;
            stp_reg      <= 1'b0;
            refp_reg     <= 1'b0;
         end else begin
            stp_reg  <= 1'b0;
            refp_reg <= ref_take;
            case (st_reg)
               S_IDLE, S_DONE: begin
                  if (start_cmd && !bad_cfg) begin
                     st_reg       <= S_ARMED;
                     smp_cnt_reg  <= 32'h0;
                     post_cnt_reg <= 32'h0;
                     ref_seen_reg <= 1'b0;
                  end
               end
               S_ARMED: begin
                  if (stop_cmd) begin
                     st_reg <= S_DONE;
                  end else if (start_hit) begin
                     stp_reg     <= 1'b1;
                     dly_cnt_reg <= 32'h0;
                     if (cfg.int_clk && dly_reg != 32'h0) begin
                        st_reg <= S_DELAY;
                     end else begin
                        st_reg <= S_RUN;
                     end
                  end
               end
               S_DELAY: begin
                  dly_cnt_reg <= dly_cnt_reg + 32'h1;
                  if (stop_cmd) begin
                     st_reg <= S_DONE;
                  end else if (dly_cnt_reg + 32'h1 >= dly_reg) begin
                     st_reg <= S_RUN;
                  end
               end
               S_RUN: begin
                  if (smp) begin
                     smp_cnt_reg <= smp_cnt_reg + 32'h1;
                  end
                  if (ref_take) begin
                     ref_seen_reg <= 1'b1;
                  end
                  if (smp && ref_seen_reg) begin
                     post_cnt_reg <= post_cnt_reg + 32'h1;
                  end
                  if (stop_cmd) begin
                     st_reg <= S_DONE;
                  end else if (cfg.mode == MD_FINITE && smp && smp_cnt_reg + 32'h1 >= cnt_reg) begin
                     st_reg <= S_DONE;
                  end else if (ref_take && post_tgt == 32'h0) begin
                     st_reg <= S_DONE;
                  end else if (ref_seen_reg && smp && post_cnt_reg + 32'h1 >= post_tgt) begin
                     st_reg <= S_DONE;
                  end
               end
               default: st_reg <= S_IDLE;
            endcase
         end
      end

      always_ff @(posedge CORE_CLK_I) begin
         if (!rst_n_reg || (st_reg == S_ARMED && start_hit)) begin
            div_cnt_reg <= 16'h0;
         end else if (st_reg == S_RUN && !paused && tb_tick) begin
            div_cnt_reg <= div_hit ? 16'h0 : div_cnt_reg + 16'h1;
         end
      end

      // Acquisition FIFO; the read pop comes from the bus
      assign full    = (fcnt_reg == (PW+1)'(FIFO_DEPTH));
      assign empty   = (fcnt_reg == '0);
      assign ovr     = smp & ((cfg.mode == MD_UNBUFFERED_HARDWARE_TIMED_MODE) ? ~empty :
                              (cfg.mode == MD_REF && !ref_seen_reg && full));
      assign push    = smp & (~full | ovr);
      assign popr    = take_ar & ~S_AXI_ARADDR_I[8] & (S_AXI_ARADDR_I[7:5] == 3'(e)) &
                       (S_AXI_ARADDR_I[4:0] == OFF_DATA) & ~empty;
      // A read that meets an overwrite takes the word being dropped
      assign pop_any = popr | ovr;
      assign wp      = rd_ptr_reg + fcnt_reg[PW-1:0];

      always_ff @(posedge CORE_CLK_I) begin
         if (!rst_n_reg) begin
            rd_ptr_reg <= '0;
            fcnt_reg   <= '0;
         end else begin
            if (pop_any) begin
               rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop_any) begin
               fcnt_reg <= fcnt_reg + 1'b1;
            end else if (!push && pop_any) begin
               fcnt_reg <= fcnt_reg - 1'b1;
            end
         end
      end

      always_ff @(posedge CORE_CLK_I) begin
         if (push) begin
            mem[wp] <= DI_LINES_I;
         end
      end

      // Sticky flags: a new event beats a same-cycle clear
      always_ff @(posedge CORE_CLK_I) begin
         if (!rst_n_reg) begin
            ovf_reg  <= 1'b0;
            late_reg <= 1'b0;
            err_reg  <= 1'b0;
            str_reg  <= 1'b0;
         end else begin
            str_reg <= smp;
            if (smp && full && !ovr) begin
               ovf_reg <= 1'b1;
            end else if (clr[STB_OVF]) begin
               ovf_reg <= 1'b0;
            end
            if (ovr && cfg.mode == MD_UNBUFFERED_HARDWARE_TIMED_MODE && !popr) begin
               late_reg <= 1'b1;
            end else if (clr[STB_LATE]) begin
               late_reg <= 1'b0;
            end
            if (start_cmd && bad_cfg && (st_reg == S_IDLE || st_reg == S_DONE)) begin
               err_reg <= 1'b1;
            end else if (clr[STB_ERR]) begin
               err_reg <= 1'b0;
            end
         end
      end

      assign stat = '{rsv: 23'h0, full: full, empty: empty, ref_seen: ref_seen_reg,
                      cfg_err: err_reg, late: late_reg, ovf: ovf_reg, state: st_reg};
      assign str_w[e]    = str_reg;
      assign stp_w[e]    = stp_reg;
      assign refp_w[e]   = refp_reg;
      assign rview[e][0] = ctrl_reg;
      assign rview[e][1] = div_reg;
      assign rview[e][2] = cnt_reg;
      assign rview[e][3] = pre_reg;
      assign rview[e][4] = dly_reg;
      assign rview[e][5] = tim_reg;
      assign rview[e][6] = stat;
      assign rview[e][7] = empty ? 32'h0 : 32'(mem[rd_ptr_reg]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin routing; the timebase has no route by design
   always_ff @(posedge CORE_CLK_I) begin
      if (!rst_n_reg) begin
         route_reg <= RST_ZERO;
      end else if (do_wr && aw_addr_reg[8:2] == OFF_ROUTE[8:2]) begin
         route_reg <= merge(route_reg, w_data_reg, wmask);
      end
   end

   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      logic [7:0] sel;
      assign sel = route_reg[8*p +: 8];
      always_ff @(posedge CORE_CLK_I) begin
         if (!rst_n_reg) begin
            PTP_O[p]    <= 1'b0;
            PTP_OE_O[p] <= 1'b0;
         end else begin
            PTP_OE_O[p] <= sel[7];
            case (sel[3:2])
               2'h0:    PTP_O[p] <= ~str_w[sel[6:4]];
               2'h1:    PTP_O[p] <= stp_w[sel[6:4]];
               2'h2:    PTP_O[p] <= refp_w[sel[6:4]] ^ sel[0];
               default: PTP_O[p] <= 1'b0;
            endcase
         end
      end
   end

endmodule

// file: verilog/dte_pkg.sv
package dte_pkg;
   localparam int NUM_ENG  = 8;
   localparam int NUM_PINS = 3;
   localparam int SRC_W    = 16;

   // Per-engine register offsets; engine e sits at byte address e*32
   localparam logic [4:0] OFF_CTRL  = 5'h00;
   localparam logic [4:0] OFF_DIV   = 5'h04;
   localparam logic [4:0] OFF_COUNT = 5'h08;
   localparam logic [4:0] OFF_PRE   = 5'h0C;
   localparam logic [4:0] OFF_DELAY = 5'h10;
   localparam logic [4:0] OFF_TIME  = 5'h14;
   localparam logic [4:0] OFF_STAT  = 5'h18;
   localparam logic [4:0] OFF_DATA  = 5'h1C;
   localparam logic [8:0] OFF_ROUTE = 9'h100;

   localparam logic [31:0] RST_CTRL  = 32'h00000040;
   localparam logic [31:0] RST_DIV   = 32'h00000002;
   localparam logic [31:0] RST_COUNT = 32'h00000010;
   localparam logic [31:0] RST_ZERO  = 32'h00000000;

   localparam int STB_OVF  = 3;
   localparam int STB_LATE = 4;
   localparam int STB_ERR  = 5;

   // Source vector: 0..2 pins, 3 analog compare, 4 output engine,
   // 5 counter, 6 frequency out, 7 change event, 8..15 input engines
   localparam logic [3:0] SRC_TB_CORE = 4'h0;
   localparam logic [3:0] SRC_CHG     = 4'h7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MD_FINITE = 2'b00, MD_CONT = 2'b01, MD_REF = 2'b10, MD_UNBUFFERED_HARDWARE_TIMED_MODE = 2'b11
   } dte_mode_e;
   typedef enum logic [1:0] {
      TT_SCLK = 2'b00, TT_CHG = 2'b01, TT_BAD2 = 2'b10, TT_BAD3 = 2'b11
   } dte_timing_e;
   typedef enum logic [1:0] {
      ST_SW = 2'b00, ST_DIG = 2'b01, ST_TIME = 2'b10, ST_NONE = 2'b11
   } dte_start_e;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_ARMED = 3'b001, S_DELAY = 3'b010,
      S_RUN = 3'b011, S_DONE = 3'b100
   } dte_state_e;

   typedef struct packed {
      logic [1:0]  spare;
      logic        pause_lvl;
      logic        pause_en;
      logic [3:0]  ref_src;
      logic        ref_fall;
      logic [3:0]  start_src;
      logic        start_fall;
      dte_start_e  start_type;
      logic [3:0]  tb_src;
      logic [3:0]  clk_src;
      logic        clk_fall;
      logic        int_clk;
      dte_timing_e timing;
      dte_mode_e   mode;
      logic        stop;
      logic        start;
   } dte_ctrl_s;

   typedef struct packed {
      logic [22:0] rsv;
      logic        full;
      logic        empty;
      logic        ref_seen;
      logic        cfg_err;
      logic        late;
      logic        ovf;
      dte_state_e  state;
   } dte_stat_s;
endpackage
